// ### ddo_pkg.sv
// Constants for the dither and manual offset register group.
// Assumes an 8-bit page-0 register address and 8-bit data from the control port.
package ddo_pkg;
   localparam logic [7:0] DDO_ADDR_DITHER_A   = 8'h4b;
   localparam logic [7:0] DDO_ADDR_DITHER_B   = 8'h4c;
   localparam logic [7:0] DDO_ADDR_LEFT_OFS   = 8'h4e;
   localparam logic [7:0] DDO_ADDR_RIGHT_OFS  = 8'h4f;
   localparam logic [7:0] DDO_ADDR_SPARE_A    = 8'h50;
   localparam logic [7:0] DDO_ADDR_SPARE_B    = 8'h51;
   localparam logic [7:0] DDO_ADDR_PIN1_SEL   = 8'h52;
   localparam logic [7:0] DDO_RESET_VALUE     = 8'h00;
   localparam int         DDO_SEL_LSB         = 0;
   localparam int         DDO_SEL_WIDTH       = 5;
   localparam int         DDO_DITHER_WIDTH    = 16;
   localparam int         DDO_OFS_WIDTH       = 8;
   localparam int         DDO_OFS_FRAC_BITS   = 2;
endpackage : ddo_pkg

// ### ddo_pin_mux.sv
// Output selector for general-purpose pin 1.
// Assumes the source vector is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ddo_pin_mux #(
   parameter int SEL_WIDTH = 5
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic [SEL_WIDTH-1:0]      sel,
   input  wire logic [(1<<SEL_WIDTH)-1:0] sources,
   input  wire logic                      output_mode,
   output logic                           pin_out,
   output logic                           pin_oe
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         // Undefined codes are tied to zero by the caller in the source vector.
         pin_out <= output_mode ? sources[sel] : 1'b0; // R7
         pin_oe  <= output_mode;                       // R7
      end
   end
endmodule // ddo_pin_mux
`default_nettype wire

// ### ddo_regs.sv
// Dither and manual DC offset registers with the pin 1 output selector.
// Assumes the control-port slave delivers single-cycle read and write strobes on clk.
// Assumes pin 1's output mode comes from the pin direction settings held elsewhere.
//
// What this block and its host model do
// R1: Dither byte pair is unsigned Q0.11 fraction.
// R2: Code zero adds nothing; LSB is 2^-11 unit.
// R3: Dither goes only to right secondary modulator.
// R4: Left offset is minus code over four mV.
// R5: Right offset uses same scaling, own byte.
// R6: Offset byte is two's complement, quarter-mV steps.
// R7: Pin shows selection only in output mode.
// R8: Host writes zero to reserved bits.
`timescale 1ns/1ps
`default_nettype none
module ddo_regs
   import ddo_pkg::*;
#(
   parameter int SEL_WIDTH = ddo_pkg::DDO_SEL_WIDTH
) (
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic [7:0]                     reg_addr,
   input  wire logic [7:0]                     reg_wdata,
   input  wire logic                           reg_write,
   input  wire logic                           reg_read,
   output logic [7:0]                          reg_rdata,
   output logic                                reg_hit,
   input  wire logic [(1<<SEL_WIDTH)-1:0]      pin1_sources,
   input  wire logic                           pin1_output_mode,
   output logic [ddo_pkg::DDO_DITHER_WIDTH-1:0] right_secondary_dc_dither,
   output logic signed [ddo_pkg::DDO_OFS_WIDTH:0] left_manual_offset,
   output logic signed [ddo_pkg::DDO_OFS_WIDTH:0] right_manual_offset,
   output logic                                pin1_out,
   output logic                                pin1_oe
);
   import ddo_pkg::*;

   // Every register clears to zero, so no dither or offset reaches the datapath after reset.
   logic [7:0] right_secondary_dc_dither_a;
   logic [7:0] right_secondary_dc_dither_b;
   logic [7:0] left_manual_dc_offset;
   logic [7:0] right_manual_dc_offset;
   logic [7:0] spare_reg_a;
   logic [7:0] spare_reg_b;
   logic [7:0] pin1_output_select;
   logic [7:0] read_value;

   // One decoded strobe per register keeps every storage process to one concern.
   logic       write_dither_a;
   logic       write_dither_b;
   logic       write_left_ofs;
   logic       write_right_ofs;
   logic       write_spare_a;
   logic       write_spare_b;
   logic       write_pin1_sel;

   assign write_dither_a  = reg_write && (reg_addr == DDO_ADDR_DITHER_A);
   assign write_dither_b  = reg_write && (reg_addr == DDO_ADDR_DITHER_B);
   assign write_left_ofs  = reg_write && (reg_addr == DDO_ADDR_LEFT_OFS);
   assign write_right_ofs = reg_write && (reg_addr == DDO_ADDR_RIGHT_OFS);
   assign write_spare_a   = reg_write && (reg_addr == DDO_ADDR_SPARE_A);
   assign write_spare_b   = reg_write && (reg_addr == DDO_ADDR_SPARE_B);
   assign write_pin1_sel  = reg_write && (reg_addr == DDO_ADDR_PIN1_SEL);

   // Offset in quarter millivolts is the negated signed code; widened so 0x80 gives +128.
   function automatic logic signed [DDO_OFS_WIDTH:0] neg_offset(input logic [7:0] code);
      logic signed [DDO_OFS_WIDTH:0] wide;
      wide = {code[7], code};
      return -wide;
   endfunction

   // Address 0x4d sits inside the range but belongs to no register here, so the
   // mapped addresses are listed one by one rather than tested as a range.
   function automatic logic hit(input logic [7:0] a);
      case (a)
         DDO_ADDR_DITHER_A,
         DDO_ADDR_DITHER_B,
         DDO_ADDR_LEFT_OFS,
         DDO_ADDR_RIGHT_OFS,
         DDO_ADDR_SPARE_A,
         DDO_ADDR_SPARE_B,
         DDO_ADDR_PIN1_SEL: return 1'b1;
         default:           return 1'b0;
      endcase
   endfunction

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         right_secondary_dc_dither_a <= DDO_RESET_VALUE;
      end else if (write_dither_a) begin
         right_secondary_dc_dither_a <= reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         right_secondary_dc_dither_b <= DDO_RESET_VALUE;
      end else if (write_dither_b) begin
         right_secondary_dc_dither_b <= reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         left_manual_dc_offset <= DDO_RESET_VALUE;
      end else if (write_left_ofs) begin
         left_manual_dc_offset <= reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         right_manual_dc_offset <= DDO_RESET_VALUE;
      end else if (write_right_ofs) begin
         right_manual_dc_offset <= reg_wdata;
      end
   end

   // Reserved registers keep what is written so read-modify-write is harmless.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spare_reg_a <= DDO_RESET_VALUE;
      end else if (write_spare_a) begin
         spare_reg_a <= reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spare_reg_b <= DDO_RESET_VALUE;
      end else if (write_spare_b) begin
         spare_reg_b <= reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin1_output_select <= DDO_RESET_VALUE;
      end else if (write_pin1_sel) begin
         pin1_output_select <= reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= read_value;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_hit <= 1'b0;
      end else if (reg_read) begin
         reg_hit <= hit(reg_addr);
      end
   end

   // Read data comes from the registers as they stand before the edge, so a write
   // in the same cycle as a read returns the value held before that write.
   always_comb begin
      read_value = 8'h00;
      case (reg_addr)
         DDO_ADDR_DITHER_A:  read_value = right_secondary_dc_dither_a;
         DDO_ADDR_DITHER_B:  read_value = right_secondary_dc_dither_b;
         DDO_ADDR_LEFT_OFS:  read_value = left_manual_dc_offset;
         DDO_ADDR_RIGHT_OFS: read_value = right_manual_dc_offset;
         DDO_ADDR_SPARE_A:   read_value = spare_reg_a;
         DDO_ADDR_SPARE_B:   read_value = spare_reg_b;
         DDO_ADDR_PIN1_SEL:  read_value = pin1_output_select;
         default:            read_value = 8'h00;
      endcase
   end

   // The dither word feeds only the right secondary modulator's low part; it is
   // Q0.11 of one thirty-second full scale, so zero adds no dither at all.
   // The two bytes are written one at a time, so the word holds half of a new
   // setting for the cycles between the two writes.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         right_secondary_dc_dither <= '0;
      end else begin
         right_secondary_dc_dither <= {right_secondary_dc_dither_a, right_secondary_dc_dither_b}; // R1 R2 R3
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         left_manual_offset <= '0;
      end else begin
         left_manual_offset <= neg_offset(left_manual_dc_offset); // R4 R6
      end
   end

   // The right channel has a process of its own, so its offset timing can be
   // changed later without touching the left channel.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         right_manual_offset <= '0;
      end else begin
         right_manual_offset <= neg_offset(right_manual_dc_offset); // R5 R6
      end
   end

   // The output enable follows the mode alone, so a selected source that is tied
   // to zero drives the pin low rather than leaving it floating.
   ddo_pin_mux #(
      .SEL_WIDTH (SEL_WIDTH)
   ) u_pin1 (
      .clk         (clk),
      .rst         (rst),
      .sel         (pin1_output_select[DDO_SEL_LSB +: SEL_WIDTH]),
      .sources     (pin1_sources),
      .output_mode (pin1_output_mode),
      .pin_out     (pin1_out),
      .pin_oe      (pin1_oe)
   );
endmodule // ddo_regs
`default_nettype wire

// ### ddo_host.sv
// Host model: issues single-cycle write and read strobes.
// Assumes the register block samples strobes on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module ddo_host
   import ddo_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   input  wire logic       hit,
   output logic [7:0]      addr,
   output logic [7:0]      wdata,
   output logic            wr_s,
   output logic            rd_s
);
   initial {addr, wdata, wr_s, rd_s} = 18'h0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= (a == DDO_ADDR_SPARE_A || a == DDO_ADDR_SPARE_B) ? 8'h00 : d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      // The released data line flips so that stale data can never look valid.
      wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      d = rdata;
      h = hit;
   endtask
endmodule // ddo_host
`default_nettype wire

// ### ddo_regs_checker.sv
// Port checker for the dither and offset registers.
// Assumes one clock domain and the write-to-output latency of two edges.
`timescale 1ns/1ps
`default_nettype none
module ddo_regs_checker
   import ddo_pkg::*;
#(
   parameter int SEL_WIDTH = ddo_pkg::DDO_SEL_WIDTH
) (
   input wire logic                          clk,
   input wire logic                          rst,
   input wire logic                          reg_write,
   input wire logic                          reg_read,
   input wire logic                          reg_hit,
   input wire logic                          pin1_output_mode,
   input wire logic                          pin1_out,
   input wire logic                          pin1_oe,
   input wire logic [7:0]                    reg_addr,
   input wire logic [7:0]                    reg_wdata,
   input wire logic [7:0]                    reg_rdata,
   input wire logic [(1<<SEL_WIDTH)-1:0]     pin1_sources,
   input wire logic [DDO_DITHER_WIDTH-1:0]   right_secondary_dc_dither,
   input wire logic signed [DDO_OFS_WIDTH:0] left_manual_offset,
   input wire logic signed [DDO_OFS_WIDTH:0] right_manual_offset
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_left_offset: assert property (reg_write && reg_addr == DDO_ADDR_LEFT_OFS |-> ##2
      left_manual_offset == -9'($signed($past(reg_wdata, 2)))) else $error("left offset wrong");
   a_right_offset: assert property (reg_write && reg_addr == DDO_ADDR_RIGHT_OFS |-> ##2
      right_manual_offset == -9'($signed($past(reg_wdata, 2)))) else $error("right offset wrong");
   a_dither_high: assert property (reg_write && reg_addr == DDO_ADDR_DITHER_A |-> ##2
      right_secondary_dc_dither[15:8] == $past(reg_wdata, 2)) else $error("dither high wrong");
   a_dither_low: assert property (reg_write && reg_addr == DDO_ADDR_DITHER_B |-> ##2
      right_secondary_dc_dither[7:0] == $past(reg_wdata, 2)) else $error("dither low wrong");
   a_reset_zero: assert property ($fell(rst) |-> right_secondary_dc_dither == '0 &&
      left_manual_offset == '0 && right_manual_offset == '0) else $error("not zero after reset");
   a_unmapped_read: assert property (reg_read && !reg_write && reg_addr == 8'h4d |=>
      !reg_hit && reg_rdata == 8'h00) else $error("unmapped read answered");
   a_pin_quiet: assert property (!pin1_output_mode |=> !pin1_oe && !pin1_out) else $error("pin driven");
   a_pin_enable: assert property (pin1_output_mode |=> pin1_oe) else $error("pin not enabled");
endmodule // ddo_regs_checker
bind ddo_regs ddo_regs_checker #(
   .SEL_WIDTH (SEL_WIDTH)
) chk (
   .clk                       (clk),
   .rst                       (rst),
   .reg_write                 (reg_write),
   .reg_read                  (reg_read),
   .reg_hit                   (reg_hit),
   .pin1_output_mode          (pin1_output_mode),
   .pin1_out                  (pin1_out),
   .pin1_oe                   (pin1_oe),
   .reg_addr                  (reg_addr),
   .reg_wdata                 (reg_wdata),
   .reg_rdata                 (reg_rdata),
   .pin1_sources              (pin1_sources),
   .right_secondary_dc_dither (right_secondary_dc_dither),
   .left_manual_offset        (left_manual_offset),
   .right_manual_offset       (right_manual_offset)
);
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the dither and offset registers.
// Assumes the host model in ddo_host and the package constants.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ddo_pkg::*;
   logic clk = 1'b0, rst = 1'b1, mode = 1'b0, wr_s, rd_s, hit, pout, poe;
   logic [31:0] src = 32'h0;
   logic [7:0] addr, wdata, rdata;
   logic [15:0] dith;
   logic signed [8:0] lofs, rofs;
   int mismatches = 0, checks_done = 0;
   initial forever #4 clk = ~clk;
   ddo_host host (.clk(clk), .rdata(rdata), .hit(hit), .addr(addr), .wdata(wdata), .wr_s(wr_s), .rd_s(rd_s));
   ddo_regs dut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s),
      .reg_rdata(rdata), .reg_hit(hit), .pin1_sources(src), .pin1_output_mode(mode),
      .right_secondary_dc_dither(dith), .left_manual_offset(lofs), .right_manual_offset(rofs),
      .pin1_out(pout), .pin1_oe(poe));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rcmp(input logic [7:0] a, input logic [7:0] e, input logic eh);
      logic [7:0] d;
      logic h;
      host.rd(a, d, h);
      cmp({d, 7'h0, h}, {e, 7'h0, eh});
   endtask
   task automatic wr2(input logic [7:0] a, input logic [7:0] d, input logic [7:0] b, input logic [7:0] e);
      host.wr(a, d);
      host.wr(b, e);
      repeat (2) @(negedge clk);
   endtask
   task automatic test_reset;
      cmp(dith, 16'h0000);
      cmp({7'h0, lofs}, 16'h0000);
      cmp({7'h0, rofs}, 16'h0000);
      rcmp(DDO_ADDR_RIGHT_OFS, 8'h00, 1'b1);
      $display("reset done");
   endtask
   task automatic test_offsets;
      wr2(DDO_ADDR_LEFT_OFS, 8'h7f, DDO_ADDR_RIGHT_OFS, 8'h80);
      cmp({7'h0, lofs}, 16'h0181);
      cmp({7'h0, rofs}, 16'h0080);
      wr2(DDO_ADDR_LEFT_OFS, 8'hff, DDO_ADDR_RIGHT_OFS, 8'h01);
      cmp({lofs, rofs[8:2]}, {9'h001, 7'h7f});
      cmp({7'h0, rofs}, 16'h01ff);
      rcmp(DDO_ADDR_LEFT_OFS, 8'hff, 1'b1);
      $display("offsets done");
   endtask
   task automatic test_dither;
      wr2(DDO_ADDR_DITHER_A, 8'h00, DDO_ADDR_DITHER_B, 8'h01);
      cmp(dith, 16'h0001);
      wr2(DDO_ADDR_DITHER_A, 8'h80, DDO_ADDR_DITHER_B, 8'h02);
      cmp(dith, 16'h8002);
      host.wr(8'h4d, 8'h5a);
      rcmp(8'h4d, 8'h00, 1'b0);
      rcmp(DDO_ADDR_DITHER_B, 8'h02, 1'b1);
      $display("dither done");
   endtask
   task automatic test_pin;
      @(posedge clk);
      src <= 32'h0000_0004;
      wr2(DDO_ADDR_SPARE_A, 8'h00, DDO_ADDR_PIN1_SEL, 8'h02);
      cmp({14'h0, pout, poe}, 16'h0000);
      @(posedge clk);
      mode <= 1'b1;
      repeat (2) @(negedge clk);
      cmp({14'h0, pout, poe}, 16'h0003);
      wr2(DDO_ADDR_SPARE_B, 8'h00, DDO_ADDR_PIN1_SEL, 8'h03);
      cmp({14'h0, pout, poe}, 16'h0001);
      rcmp(DDO_ADDR_SPARE_B, 8'h00, 1'b1);
      rcmp(DDO_ADDR_PIN1_SEL, 8'h03, 1'b1);
      $display("pin done");
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      test_reset();
      test_offsets();
      test_dither();
      test_pin();
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
